// [rtl/otp_cmd_pkg.sv]
// Constants, opcodes and state encodings for the OTP and mode command core.
// Assumes a single 10 MHz system clock that samples the serial pins.
package otp_cmd_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100; // System clock period.
    localparam int OTP_PROGRAM_TIME_NS = 200000; // Program duration.
    localparam int OTP_TIMEOUT_NS = 400000; // Program gives up here.
    localparam int POWERDOWN_ENTRY_DELAY_NS = 3000; // Entry delay.
    localparam int POWERDOWN_RELEASE_DELAY_NS = 30000; // Release delay.
    localparam int RESET_RECOVERY_NS = 40000; // Reset recovery time.
    // Least times round up to whole clock cycles.
    localparam int OTP_PROGRAM_CYCLES =
        (OTP_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OTP_TIMEOUT_CYCLES =
        (OTP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERDOWN_ENTRY_CYCLES =
        (POWERDOWN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERDOWN_RELEASE_CYCLES =
        (POWERDOWN_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVERY_CYCLES =
        (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16; // Width of the shared delay timer.

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_READ_OTP = 8'h4b;
    localparam logic [7:0] OP_PROGRAM_OTP = 8'h42;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_READ_FLAGS = 8'h70;
    localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;
    localparam logic [7:0] OP_ENTER_4BYTE = 8'hb7;
    localparam logic [7:0] OP_EXIT_4BYTE = 8'he9;
    localparam logic [7:0] OP_ENTER_POWERDOWN = 8'hb9;
    localparam logic [7:0] OP_RELEASE_POWERDOWN = 8'hab;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
    localparam logic [7:0] OP_RESET_QUAD = 8'hf5;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;

    // ------------------------------------------------------------------
    // OTP array layout and flag status fields
    // ------------------------------------------------------------------
    localparam int OTP_BYTES = 65; // 64 data bytes plus control byte.
    localparam logic [6:0] OTP_LAST_ADDR = 7'h40; // Control byte.
    localparam logic [6:0] OTP_PTR_FULL = 7'h41; // Program buffer full.
    localparam int OTP_LOCK_BIT = 0; // Lock bit in the control byte.
    localparam logic [7:0] OTP_ERASED = 8'hff; // Unprogrammed byte.
    localparam int DUMMY_BYTES = 1; // Dummy clocks of a read, in bytes.
    localparam int FLAG_READY_BIT = 7; // Controller ready.
    localparam int FLAG_FAIL_BIT = 4; // Program failure.
    localparam int FLAG_PROT_BIT = 1; // Protection error.

    // ------------------------------------------------------------------
    // Device states, Gray coded along idle-enter-down-wake
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PROG = 3'h4,
        ST_DPD_ENTER = 3'h1,
        ST_DPD = 3'h3,
        ST_WAKE = 3'h2
    } dev_state_t;

endpackage

// [rtl/pin_filter.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins change slowly against the sampling clock.
module pin_filter
    import otp_cmd_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] ff1; // First stage, read only by the second.
        logic [W-1:0] ff2; // Second stage.
        logic [W-1:0] ff3; // Third stage.
        logic [W-1:0] level; // Accepted level.
    } filt_t;

    filt_t r; // Registered state.
    filt_t next_r; // Next state.

    // A bit is accepted once the second and third stages agree.
    always_comb begin
        next_r = r;
        next_r.ff1 = pin_in;
        next_r.ff2 = r.ff1;
        next_r.ff3 = r.ff2;
        next_r.level = (~(r.ff2 ^ r.ff3) & r.ff2)
            | ((r.ff2 ^ r.ff3) & r.level);
    end

    // Registers all stages.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign level_out = r.level;

endmodule

// [rtl/otp_mode_cmd_core.sv]
// Serial command core: OTP read and program, address width, deep
// power-down and quad mode. Assumes a host driving select, clock and
// data far slower than REF_CLK_IN, which samples and edge-detects them.
module otp_mode_cmd_core
    import otp_cmd_pkg::*;
#(
    parameter int PROGRAM_CYCLES = OTP_PROGRAM_CYCLES,
    parameter int TIMEOUT_CYCLES = OTP_TIMEOUT_CYCLES,
    parameter int ENTRY_CYCLES = POWERDOWN_ENTRY_CYCLES,
    parameter int RELEASE_CYCLES = POWERDOWN_RELEASE_CYCLES,
    parameter int RECOVERY_CYCLES = RESET_RECOVERY_CYCLES
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic SEL_N_IN,
    input wire logic SERIAL_CLK_IN,
    input wire logic SERIAL_IN_LINE_IN,
    input wire logic PROGRAM_FAULT_IN,
    output logic SERIAL_OUT_LINE_OUT,
    output logic SERIAL_OUT_LINE_OE_OUT,
    output logic WRITE_ENABLE_LATCH_OUT,
    output logic WRITE_IN_PROGRESS_OUT,
    output logic [7:0] FLAG_STATUS_OUT,
    output logic FOUR_BYTE_MODE_OUT,
    output logic QUAD_MODE_OUT,
    output logic DEEP_POWER_DOWN_OUT
);

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    logic [2:0] pins; // Filtered select, clock and data.
    logic sel_n; // Filtered select, low during a frame.
    logic sclk; // Filtered serial clock.
    logic din; // Filtered serial input line.

    pin_filter #(
        .W(3),
        .RESET_VAL(3'h4)
    ) u_pins (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .pin_in({SEL_N_IN, SERIAL_CLK_IN, SERIAL_IN_LINE_IN}),
        .level_out(pins)
    );

    assign sel_n = pins[2];
    assign sclk = pins[1];
    assign din = pins[0];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dev_state_t state; // Device state.
        logic [TIMER_W-1:0] timer; // Shared delay timer.
        logic sel_d; // Select level of the previous cycle.
        logic clk_d; // Serial clock level of the previous cycle.
        logic [2:0] bit_idx; // Bit within the current byte.
        logic [7:0] byte_idx; // Completed bytes, saturating.
        logic [6:0] shift; // Input shift register.
        logic [7:0] opcode; // Opcode of the current frame.
        logic [31:0] addr; // Address bytes received.
        logic [6:0] wptr; // Program buffer write index.
        logic has_data; // A program data byte arrived.
        logic [6:0] rptr; // Read index into the array.
        logic [7:0] out_shift; // Output shift register.
        logic [2:0] out_cnt; // Bits shifted out of this byte.
        logic dout; // Output line value.
        logic oe; // Output line enable.
        logic write_enable_latch; // Write enable latch.
        logic four_byte; // 4-byte addressing active.
        logic quad; // Quad protocol active.
        logic rst_armed; // Reset enable seen last frame.
        logic flag_prot; // Protection error flag.
        logic flag_fail; // Program failure flag.
        logic [OTP_BYTES-1:0][7:0] mem; // OTP array and control byte.
        logic [OTP_BYTES-1:0][7:0] pbuf; // Program data buffer.
    } core_t;

    core_t r; // Registered state.
    core_t next_r; // Next state.

    // ------------------------------------------------------------------
    // Derived terms
    // ------------------------------------------------------------------
    logic [7:0] flags; // Flag status byte.
    logic [7:0] new_byte; // Byte completed on this rising edge.
    logic [7:0] addr_bytes; // Address bytes of this frame.
    logic [7:0] read_hdr; // Bytes before read data starts.
    logic reading; // Frame is an accepted read.
    logic exact8; // Frame held exactly one byte.
    logic whole; // Frame ended on a byte boundary.

    // Builds the flag byte; ready is low only while a program runs.
    always_comb begin
        flags = '0;
        flags[FLAG_READY_BIT] = (r.state != ST_PROG);
        flags[FLAG_FAIL_BIT] = r.flag_fail;
        flags[FLAG_PROT_BIT] = r.flag_prot;
    end

    assign new_byte = {r.shift, din};
    assign addr_bytes = r.four_byte ? 8'h04 : 8'h03;
    assign read_hdr = (r.opcode == OP_READ_FLAGS) ? 8'h01
        : 8'(8'h01 + addr_bytes + 8'(DUMMY_BYTES));
    assign exact8 = (r.byte_idx == 8'h01) && (r.bit_idx == 3'h0);
    assign whole = (r.bit_idx == 3'h0);

    // Only OTP reads in standby and flag reads in standby or programming
    // drive the output line.
    always_comb begin
        reading = 1'b0;
        if (r.opcode == OP_READ_OTP) begin
            reading = (r.state == ST_IDLE);
        end else if (r.opcode == OP_READ_FLAGS) begin
            reading = (r.state == ST_IDLE) || (r.state == ST_PROG);
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] a; // Address after this byte.
        logic [6:0] p; // Advanced read index.
        a = '0;
        p = '0;
        next_r = r;
        next_r.sel_d = sel_n;
        next_r.clk_d = sclk;

        // Background timers of the device state machine.
        case (r.state)
            ST_IDLE: begin
                next_r.timer = '0;
            end
            ST_PROG: begin
                // Busy until the program time passes without a fault, or time runs out.
                next_r.timer = r.timer + 1'b1;
                if (!PROGRAM_FAULT_IN &&
                    r.timer >= TIMER_W'(PROGRAM_CYCLES - 1)) begin
                    next_r.mem = r.mem & r.pbuf;
                    next_r.write_enable_latch = 1'b0;
                    next_r.state = ST_IDLE;
                end else if (r.timer >= TIMER_W'(TIMEOUT_CYCLES - 1)) begin
                    next_r.flag_fail = 1'b1;
                    next_r.write_enable_latch = 1'b0;
                    next_r.state = ST_IDLE;
                end
            end
            ST_DPD_ENTER: begin
                // Power-down is reached only once the entry delay ends.
                if (r.timer == '0) begin
                    next_r.state = ST_DPD;
                end else begin
                    next_r.timer = r.timer - 1'b1;
                end
            end
            ST_DPD: begin
                next_r.timer = '0;
            end
            ST_WAKE: begin
                // Release or reset recovery; frames are ignored here.
                if (r.timer == '0) begin
                    next_r.state = ST_IDLE;
                end else begin
                    next_r.timer = r.timer - 1'b1;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
                next_r.timer = '0;
            end
        endcase

        if (r.sel_d && !sel_n) begin
            // Frame start: clear the byte machinery.
            next_r.bit_idx = '0;
            next_r.byte_idx = '0;
            next_r.shift = '0;
            next_r.opcode = '0;
            next_r.addr = '0;
            next_r.out_cnt = '0;
            next_r.has_data = 1'b0;
            next_r.wptr = OTP_PTR_FULL;
            // A running program still needs its buffer; polls keep it.
            if (r.state != ST_PROG) begin
                next_r.pbuf = '1;
            end
            next_r.oe = 1'b0;
        end else if (!sel_n && !r.clk_d && sclk) begin
            // Rising serial edge: sample one bit.
            next_r.shift = new_byte[6:0];
            next_r.bit_idx = r.bit_idx + 1'b1;
            if (r.bit_idx == 3'h7) begin
                if (r.byte_idx != 8'hff) begin
                    next_r.byte_idx = r.byte_idx + 1'b1;
                end
                if (r.byte_idx == 8'h00) begin
                    next_r.opcode = new_byte;
                    // Mode commands act as soon as the opcode is in.
                    if (r.state == ST_IDLE) begin
                        if (new_byte == OP_ENTER_4BYTE) begin
                            next_r.four_byte = 1'b1;
                        end else if (new_byte == OP_EXIT_4BYTE) begin
                            next_r.four_byte = 1'b0;
                        end else if (new_byte == OP_ENTER_QUAD) begin
                            next_r.quad = !r.write_enable_latch | r.quad;
                        end else if (new_byte == OP_RESET_QUAD) begin
                            next_r.quad = 1'b0;
                        end
                    end
                end else if (r.byte_idx <= addr_bytes) begin
                    a = {r.addr[23:0], new_byte};
                    next_r.addr = a;
                    if (r.byte_idx == addr_bytes) begin
                        // Start index; out of range never wraps.
                        next_r.rptr = (a > 32'(OTP_LAST_ADDR))
                            ? OTP_LAST_ADDR : a[6:0];
                        next_r.wptr = (a > 32'(OTP_LAST_ADDR))
                            ? OTP_PTR_FULL : a[6:0];
                    end
                end else if (r.opcode == OP_PROGRAM_OTP &&
                             r.state == ST_IDLE) begin
                    // Program data; beyond the control byte it is lost.
                    next_r.has_data = 1'b1;
                    if (r.wptr <= OTP_LAST_ADDR) begin
                        next_r.pbuf[r.wptr] = new_byte;
                        next_r.wptr = r.wptr + 1'b1;
                    end
                end
                // Load the first output byte as the header completes.
                if (r.byte_idx + 8'h01 == read_hdr) begin
                    next_r.out_shift = (r.opcode == OP_READ_FLAGS)
                        ? flags : r.mem[next_r.rptr];
                end
                // A flag read answers right after its opcode byte.
                if (r.byte_idx == 8'h00 && new_byte == OP_READ_FLAGS) begin
                    next_r.out_shift = flags;
                end
            end
        end else if (!sel_n && r.clk_d && !sclk && reading &&
                     r.byte_idx >= read_hdr) begin
            // Falling serial edge in the data phase: present one bit.
            next_r.dout = r.out_shift[7];
            next_r.oe = 1'b1;
            next_r.out_shift = {r.out_shift[6:0], 1'b0};
            next_r.out_cnt = r.out_cnt + 1'b1;
            if (r.out_cnt == 3'h7) begin
                if (r.opcode == OP_READ_FLAGS) begin
                    next_r.out_shift = flags;
                end else begin
                    // Advance, then hold at the control byte.
                    p = (r.rptr == OTP_LAST_ADDR)
                        ? OTP_LAST_ADDR : r.rptr + 1'b1;
                    next_r.rptr = p;
                    next_r.out_shift = r.mem[p];
                end
            end
        end else if (!r.sel_d && sel_n) begin
            // Frame end: release the line and run end-of-frame commands.
            next_r.oe = 1'b0;
            next_r.rst_armed = 1'b0;
            case (r.state)
                ST_IDLE: begin
                    if (exact8 && r.opcode == OP_WRITE_ENABLE) begin
                        next_r.write_enable_latch = 1'b1;
                    end else if (exact8 && r.opcode == OP_CLEAR_FLAGS) begin
                        next_r.flag_prot = 1'b0;
                        next_r.flag_fail = 1'b0;
                    end else if (exact8 &&
                                 r.opcode == OP_ENTER_POWERDOWN) begin
                        next_r.state = ST_DPD_ENTER;
                        next_r.timer = TIMER_W'(ENTRY_CYCLES - 1);
                    end else if (r.opcode == OP_PROGRAM_OTP && r.write_enable_latch &&
                                 whole && r.has_data) begin
                        // Only whole frames with data start a program.
                        // Latch set, frame ended.
                        if (!r.mem[OTP_LAST_ADDR][OTP_LOCK_BIT]) begin
                            next_r.flag_prot = 1'b1;
                            next_r.flag_fail = 1'b1;
                        end else begin
                            next_r.state = ST_PROG;
                            next_r.timer = '0;
                        end
                    end
                end
                ST_DPD: begin
                    // Only release and the reset pair are heard here.
                    if (exact8 && r.opcode == OP_RELEASE_POWERDOWN) begin
                        next_r.state = ST_WAKE;
                        next_r.timer = TIMER_W'(RELEASE_CYCLES - 1);
                    end
                end
                default: begin
                    // Programming rejects power-down and program frames;
                    // the state is left to the timers so that a program
                    // finishing in this cycle is not held busy.
                    next_r.rst_armed = 1'b0;
                end
            endcase
            // Reset enable then reset, in any state that hears frames.
            if (exact8 && r.state != ST_WAKE &&
                r.state != ST_DPD_ENTER) begin
                if (r.opcode == OP_RESET_ENABLE) begin
                    next_r.rst_armed = 1'b1;
                end else if (r.opcode == OP_RESET && r.rst_armed) begin
                    next_r.state = ST_WAKE;
                    next_r.timer = TIMER_W'(RECOVERY_CYCLES - 1);
                    next_r.write_enable_latch = 1'b0;
                    next_r.four_byte = 1'b0;
                    next_r.quad = 1'b0;
                    next_r.flag_prot = 1'b0;
                    next_r.flag_fail = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register; hardware reset starts in reset recovery
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= '0;
            r.state <= ST_WAKE;
            r.timer <= TIMER_W'(RECOVERY_CYCLES - 1);
            r.sel_d <= 1'b1;
            r.wptr <= OTP_PTR_FULL;
            r.mem <= {OTP_BYTES{OTP_ERASED}};
            r.pbuf <= {OTP_BYTES{OTP_ERASED}};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign SERIAL_OUT_LINE_OUT = r.dout;
    assign SERIAL_OUT_LINE_OE_OUT = r.oe;
    assign WRITE_ENABLE_LATCH_OUT = r.write_enable_latch;
    assign WRITE_IN_PROGRESS_OUT = (r.state == ST_PROG);
    assign FLAG_STATUS_OUT = flags;
    assign FOUR_BYTE_MODE_OUT = r.four_byte;
    assign QUAD_MODE_OUT = r.quad;
    assign DEEP_POWER_DOWN_OUT = (r.state == ST_DPD);

endmodule

// [dv/otp_cmd_asserts.sv]
// Port-level checks for the OTP and mode command core.
// Assumes binding to otp_mode_cmd_core; it sees that module's ports only.
module otp_cmd_asserts (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic SEL_N_IN,
    input wire logic SERIAL_OUT_LINE_OE_OUT,
    input wire logic WRITE_ENABLE_LATCH_OUT,
    input wire logic WRITE_IN_PROGRESS_OUT,
    input wire logic [7:0] FLAG_STATUS_OUT,
    input wire logic FOUR_BYTE_MODE_OUT,
    input wire logic QUAD_MODE_OUT,
    input wire logic DEEP_POWER_DOWN_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // A program starts and then stays busy for several cycles.
    sequence prog_start; $rose(WRITE_IN_PROGRESS_OUT); endsequence
    sequence prog_run; WRITE_IN_PROGRESS_OUT [*8]; endsequence
    AST_OE_OFF: assert property (
        SEL_N_IN [*6] |-> !SERIAL_OUT_LINE_OE_OUT)
        else $error("data line driven with select high");
    AST_WIP_LEN: assert property (prog_start |-> prog_run)
        else $error("program busy too short");
    AST_WIP_BUSY: assert property (
        FLAG_STATUS_OUT[7] == !WRITE_IN_PROGRESS_OUT)
        else $error("ready flag high while busy");
    AST_WIP_LATCH: assert property (
        $fell(WRITE_IN_PROGRESS_OUT) |-> ##[0:1] !WRITE_ENABLE_LATCH_OUT)
        else $error("latch kept after program end");
    AST_WIP_DPD: assert property (
        WRITE_IN_PROGRESS_OUT |-> !DEEP_POWER_DOWN_OUT)
        else $error("power-down during program");
    AST_DPD_HOLD: assert property (
        DEEP_POWER_DOWN_OUT && $past(DEEP_POWER_DOWN_OUT) |->
        $stable(FLAG_STATUS_OUT) && $stable(FOUR_BYTE_MODE_OUT) &&
        $stable(QUAD_MODE_OUT) && $stable(WRITE_ENABLE_LATCH_OUT))
        else $error("state changed in power-down");
    AST_QUAD_WEL: assert property (
        $rose(QUAD_MODE_OUT) |-> !$past(WRITE_ENABLE_LATCH_OUT))
        else $error("quad entered with latch set");
    AST_LOCK_FLAGS: assert property (
        $rose(FLAG_STATUS_OUT[1]) |->
        FLAG_STATUS_OUT[4] && WRITE_ENABLE_LATCH_OUT)
        else $error("locked program flags wrong");
endmodule
bind otp_mode_cmd_core otp_cmd_asserts u_asserts (.*);

// [dv/otp_host_model.sv]
// Host controller model: drives select, serial clock and data in.
// Assumes the 10 MHz bench clock; serial clock period is 800 ns.
module otp_host_model (
    input wire logic clk,
    input wire logic so,
    output logic sel_n,
    output logic sck,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Half a serial clock period, in bench clock falling edges.
    task automatic hp();
        repeat (4) @(negedge clk);
    endtask
    // One framed transfer, MSB first; the clock stands still outside it.
    task automatic run(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] v;
        rx = {};
        sel_n = 1'b0;
        hp();
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                si = tx[i][k];
                hp();
                sck = 1'b1;
                hp();
                // Output lags the pins by several clocks: sample late.
                v[k] = so;
                sck = 1'b0;
            end
            rx.push_back(v);
        end
        hp();
        sel_n = 1'b1;
        si = ~si;
        hp();
        hp();
    endtask
endmodule

// [dv/otp_mode_cmd_core_test.sv]
// Self-checking bench for otp_mode_cmd_core with shortened delays.
// Assumes otp_host_model and the bound checker are compiled first.
module otp_mode_cmd_core_test;
    import otp_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, fault = 0, sel_n, sck, si, so_raw, oe;
    logic write_enable_latch, wip, fbm, qm, dpd;
    logic [7:0] flags;
    logic [7:0] rx[$];
    logic [7:0] exp_rd[4] = '{8'hff, 8'h12, 8'h34, 8'h34};
    logic [7:0] mop[4] = '{8'hb7, 8'he9, 8'h35, 8'hf5};
    logic [1:0] mexp[4] = '{2'b01, 2'b00, 2'b10, 2'b00};
    int err_count = 0, n_tests = 0;
    wire so = oe ? so_raw : 1'b1; // Pulled up when released.
    always #50 clk = ~clk;
    otp_host_model host(.clk(clk), .so(so), .sel_n(sel_n), .sck(sck),
        .si(si));
    otp_mode_cmd_core #(.PROGRAM_CYCLES(300), .TIMEOUT_CYCLES(400),
        .ENTRY_CYCLES(30), .RELEASE_CYCLES(30), .RECOVERY_CYCLES(40)) DUT(
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .SEL_N_IN(sel_n),
        .SERIAL_CLK_IN(sck), .SERIAL_IN_LINE_IN(si),
        .PROGRAM_FAULT_IN(fault), .SERIAL_OUT_LINE_OUT(so_raw),
        .SERIAL_OUT_LINE_OE_OUT(oe), .WRITE_ENABLE_LATCH_OUT(write_enable_latch),
        .WRITE_IN_PROGRESS_OUT(wip), .FLAG_STATUS_OUT(flags),
        .FOUR_BYTE_MODE_OUT(fbm), .QUAD_MODE_OUT(qm),
        .DEEP_POWER_DOWN_OUT(dpd));
    // Prints counts and verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait for a level; running out counts as a mismatch.
    task automatic waitv(ref logic s, input logic v);
        int n = 0;
        while (s !== v && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (s !== v) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic go(input logic [7:0] tx[$]);
        host.run(tx, rx);
    endtask
    task automatic hw_reset();
        @(negedge clk) rst_n = 0;
        repeat (5) @(negedge clk);
        rst_n = 1;
        repeat (50) @(negedge clk);
    endtask
    initial begin
        hw_reset();
        chk("flags", 8'h80, flags);
        go('{8'h42, 0, 0, 8'h3f, 8'ha5});
        chk("wip", 8'h00, {7'h0, wip});
        chk("flags", 8'h80, flags);
        go('{8'h06});
        go('{8'h42, 0, 0, 8'h3f, 8'h12, 8'h34});
        chk("wip", 8'h01, {7'h0, wip});
        go('{8'hb9});
        go('{8'h70, 0});
        chk("fsr", 8'h00, rx[1]);
        waitv(wip, 1'b0);
        chk("wel", 8'h00, {7'h0, write_enable_latch});
        repeat (40) @(negedge clk);
        chk("dpd", 8'h00, {7'h0, dpd});
        go('{8'h4b, 0, 0, 8'h3e, 0, 0, 0, 0, 0});
        for (int i = 0; i < 4; i++)
            chk("otp", exp_rd[i], rx[5+i]);
        chk("oe", 8'h00, {7'h0, oe});
        go('{8'h06});
        go('{8'h42, 0, 0, 0, 8'h55});
        repeat (30) @(negedge clk);
        chk("flags", 8'h92, flags);
        chk("wel", 8'h01, {7'h0, write_enable_latch});
        $display("otp program tests done");
        hw_reset();
        go('{8'h06});
        fault = 1;
        go('{8'h42, 0, 0, 0, 8'h55});
        waitv(wip, 1'b0);
        fault = 0;
        chk("flags", 8'h90, flags);
        chk("wel", 8'h00, {7'h0, write_enable_latch});
        for (int i = 0; i < 4; i++) begin
            go('{mop[i]});
            chk("mode", {6'h0, mexp[i]},
                {6'h0, qm, fbm});
        end
        $display("timeout and mode tests done");
        go('{8'hb9});
        waitv(dpd, 1'b1);
        go('{8'hb7});
        chk("fbm", 8'h00, {7'h0, fbm});
        go('{8'hab});
        waitv(dpd, 1'b0);
        repeat (40) @(negedge clk);
        go('{8'hb9});
        waitv(dpd, 1'b1);
        go('{8'hab, 0});
        chk("dpd", 8'h01, {7'h0, dpd});
        go('{8'h66});
        go('{8'h99});
        waitv(dpd, 1'b0);
        $display("power-down tests done");
        end_sim();
    end
endmodule
